// ### inc/gmd_pkg.sv
/*
  Constants, types and register map of the graphics memory and display mode
  register bank.
  Assumes one 100 MHz clock and an AXI4-Lite master with 32-bit data.
*/
// What this block does
// - reset clears memory size field and access latency select to zero
// - memory size field 5:4 picks part count, density and bus width
// - latency select bit 0 sets precharge and row-to-column latency 3 or 2
// - reset clears wrap and combine, sync mode becomes 10, refresh 1000
// - reset leaves the scan mode field holding its old value
// - filter off: foreground and background leave as separate screens
// - filter on: averaged foreground and background leave as foreground
// - filter on: colour key detection runs on the averaged pixel
// - average per 5:6:5 component: add, shift right one, drop fraction
// - wrap off: background coordinates pass unwrapped
// - wrap on: x wraps at rendering width, y wraps at 512 pixels
// - wrap area origin comes from background start bits 13 to 9
// - combine bit 10 enables merging background into display output while filter is off
// - sync mode 10 makes sync pins inputs and holds composite sync high
`default_nettype none
package gmd_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] GMD_OFS_MEM = 8'h00;
  localparam logic [7:0] GMD_OFS_DISP = 8'h04;
  localparam logic [7:0] GMD_OFS_STAT = 8'h08;

  // ****************************************
  // field positions
  // ****************************************
  localparam int GMD_MEM_LAT_BIT = 0;
  localparam int GMD_MEM_SIZE_LSB = 4;
  localparam int GMD_DISP_REF_LSB = 0;
  localparam int GMD_DISP_SCAN_LSB = 4;
  localparam int GMD_DISP_SYNC_LSB = 6;
  localparam int GMD_DISP_COMB_BIT = 10;
  localparam int GMD_DISP_WRAP_BIT = 11;
  localparam int GMD_DISP_FLT_BIT = 15;
  localparam int GMD_WRAP_Y_BITS = 9;
  localparam int GMD_BGS_ORG_LSB = 9;
  localparam int GMD_BGS_ORG_MSB = 13;

  // ****************************************
  // reset values and latency figures
  // ****************************************
  localparam logic [1:0] GMD_RST_SIZE = 2'h0;
  localparam logic GMD_RST_LAT = 1'b0;
  localparam logic [3:0] GMD_RST_REF = 4'h8;
  localparam logic [2:0] GMD_LAT_APL = 3'h5;
  localparam logic [2:0] GMD_LAT_WPL = 3'h2;
  localparam logic [2:0] GMD_LAT_SLOW = 3'h3;
  localparam logic [2:0] GMD_LAT_FAST = 3'h2;
  localparam logic [1:0] GMD_RESP_OKAY = 2'h0;
  localparam logic [1:0] GMD_RESP_SLVERR = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    GMD_SYNC_MASTER = 2'b00,
    GMD_SYNC_SWITCH = 2'b01,
    GMD_SYNC_TV = 2'b10,
    GMD_SYNC_BAD = 2'b11
  } gmd_sync_e;

  typedef struct packed {
    logic [2:0] active_to_precharge_latency;
    logic [2:0] pre;
    logic [2:0] rcd;
    logic [2:0] write_to_precharge_latency;
  } gmd_lat_s;

  typedef struct packed {
    logic bus32;
    logic two_parts;
    logic dens64;
    logic part_x32;
  } gmd_memcfg_s;

  typedef struct packed {
    logic [15:0] fg;
    logic [15:0] bg;
  } gmd_pix_s;

  typedef struct packed {
    gmd_memcfg_s mem;
    gmd_lat_s lat;
  } gmd_stat_s;

endpackage
`default_nettype wire

// ### src/gmd_filter.sv
/*
  Pixel stage: separate screens or 5:6:5 averaging, colour key match.
  Assumes pixel pairs and key come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module gmd_filter (
  input wire logic clock,
  input wire logic reset,
  input wire logic flt_en,
  input wire logic comb_en,
  input wire logic pix_valid,
  input wire gmd_pkg::gmd_pix_s pix,
  input wire logic [15:0] colour_key,
  output logic out_valid_ff,
  output logic [15:0] out_fg_ff,
  output logic [15:0] out_bg_ff,
  output logic out_bg_valid_ff,
  output logic key_hit_ff
);
  import gmd_pkg::*;

  // ****************************************
  // averaging
  // ****************************************
  // per component sum then shift; the carry keeps the sum exact
  function automatic logic [15:0] avg565(input logic [15:0] a, input logic [15:0] b);
    logic [5:0] r;
    logic [6:0] g;
    logic [5:0] bl;
    r = {1'b0, a[15:11]} + {1'b0, b[15:11]};
    g = {1'b0, a[10:5]} + {1'b0, b[10:5]};
    bl = {1'b0, a[4:0]} + {1'b0, b[4:0]};
    return {r[5:1], g[6:1], bl[5:1]};
  endfunction

  logic [15:0] fg_sel;
  // averaged or plain foreground feeds both output and key match
  assign fg_sel = flt_en ? avg565(pix.fg, pix.bg) : pix.fg;

  // ****************************************
  // output register
  // ****************************************
  // key compare on the chosen pixel, so filter mode never tests raw fg
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_valid_ff <= 1'b0;
      out_fg_ff <= 16'h0000;
      out_bg_ff <= 16'h0000;
      out_bg_valid_ff <= 1'b0;
      key_hit_ff <= 1'b0;
    end else begin
      out_valid_ff <= pix_valid;
      out_fg_ff <= fg_sel;
      out_bg_ff <= flt_en ? 16'h0000 : pix.bg;
      out_bg_valid_ff <= pix_valid && !flt_en && comb_en;
      key_hit_ff <= pix_valid && (fg_sel == colour_key);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_flt_pix;
    pix_valid && flt_en;
  endsequence

  sequence s_sep_pix;
    pix_valid && !flt_en;
  endsequence

  AST_AVG: assert property (@(posedge clock) disable iff (reset)
    s_flt_pix |=> out_fg_ff[15:11] ==
      5'((({1'b0, $past(pix.fg[15:11])} + {1'b0, $past(pix.bg[15:11])}) >> 1)))
    else $error("red average wrong");
  AST_SEP: assert property (@(posedge clock) disable iff (reset)
    s_sep_pix |=> out_fg_ff == $past(pix.fg) && out_bg_ff == $past(pix.bg))
    else $error("separate screens not passed through");
  AST_KEY: assert property (@(posedge clock) disable iff (reset)
    s_flt_pix |=> key_hit_ff == (out_fg_ff == $past(colour_key)))
    else $error("key match not on averaged pixel");
endmodule
`default_nettype wire

// ### src/gmd_regs.sv
/*
  Memory configuration and primary display mode registers behind an
  AXI4-Lite slave, with latency decode, background wrap and sync pin control.
  Assumes a single clock and a master keeping AXI4-Lite handshake rules.
*/
`timescale 1ns/1ps
`default_nettype none
module gmd_regs (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_valid,
  input wire gmd_pkg::gmd_pix_s pix,
  input wire logic [15:0] colour_key,
  input wire logic [11:0] bg_x,
  input wire logic [13:0] bg_y,
  input wire logic [11:0] rendering_memory_width,
  input wire logic [15:0] background_start_coordinate,
  output gmd_pkg::gmd_memcfg_s unified_graphics_memory,
  output gmd_pkg::gmd_lat_s mem_latency,
  output logic out_valid,
  output logic [15:0] foreground_screen,
  output logic [15:0] background_screen,
  output logic background_valid,
  output logic colour_key_detect,
  output logic [11:0] bg_fetch_x,
  output logic [13:0] bg_fetch_y,
  output logic [1:0] scan_mode,
  output logic [3:0] refresh_count,
  output logic sync_pins_oe_n,
  output logic csync_out,
  output logic display_enable
);
  import gmd_pkg::*;

  // ****************************************
  // register state
  // ****************************************
  logic [1:0] memory_size_ff;
  logic access_latency_select_ff;
  logic filter_average_enable_ff;
  logic background_wrap_enable_ff;
  logic background_combine_enable_ff;
  gmd_sync_e sync_mode_ff;
  logic [1:0] scan_mode_ff;
  logic [3:0] refresh_count_ff;

  logic aw_ok_ff;
  logic w_ok_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  gmd_memcfg_s memcfg_ff;
  gmd_lat_s lat_ff;
  logic [11:0] fetch_x_ff;
  logic [13:0] fetch_y_ff;
  logic oe_n_ff;
  logic csync_ff;
  logic disp_en_ff;

  // ****************************************
  // helpers
  // ****************************************
  // merge byte lanes; only the low two lanes hold register bits
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // reserved bits are never stored, so they read as zero
  function automatic logic [15:0] mem_view(input logic [1:0] sz, input logic lat);
    logic [15:0] v;
    v = 16'h0000;
    v[GMD_MEM_SIZE_LSB +: 2] = sz;
    v[GMD_MEM_LAT_BIT] = lat;
    return v;
  endfunction

  logic [15:0] mem_rd;
  logic [15:0] disp_rd;
  logic [15:0] mem_nv;
  logic [15:0] disp_nv;
  logic do_write;
  logic wr_mem;
  logic wr_disp;

  // current register images and their merged next images
  always_comb begin
    mem_rd = mem_view(memory_size_ff, access_latency_select_ff);
    disp_rd = 16'h0000;
    disp_rd[GMD_DISP_FLT_BIT] = filter_average_enable_ff;
    disp_rd[GMD_DISP_WRAP_BIT] = background_wrap_enable_ff;
    disp_rd[GMD_DISP_COMB_BIT] = background_combine_enable_ff;
    disp_rd[GMD_DISP_SYNC_LSB +: 2] = sync_mode_ff;
    disp_rd[GMD_DISP_SCAN_LSB +: 2] = scan_mode_ff;
    disp_rd[GMD_DISP_REF_LSB +: 4] = refresh_count_ff;
    mem_nv = merge16(mem_rd, wdata_ff, wstrb_ff);
    disp_nv = merge16(disp_rd, wdata_ff, wstrb_ff);
  end

  assign do_write = aw_ok_ff && w_ok_ff && !bvalid_ff;
  assign wr_mem = do_write && (waddr_ff[7:2] == GMD_OFS_MEM[7:2]);
  assign wr_disp = do_write && (waddr_ff[7:2] == GMD_OFS_DISP[7:2]);

  // ****************************************
  // axi write channels
  // ****************************************
  // address and data taken in either order; one write outstanding
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= GMD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_ok_ff <= 1'b1;
        awready_ff <= 1'b0;
        waddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_ok_ff <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_mem || wr_disp || waddr_ff[7:2] == GMD_OFS_STAT[7:2]) ?
                    GMD_RESP_OKAY : GMD_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // axi read channel
  // ****************************************
  // answer one cycle after the address is taken; unmapped reads zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= GMD_RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= GMD_RESP_OKAY;
      unique case (s_axi_araddr[7:2])
        GMD_OFS_MEM[7:2]: rdata_ff <= {16'h0000, mem_rd};
        GMD_OFS_DISP[7:2]: rdata_ff <= {16'h0000, disp_rd};
        GMD_OFS_STAT[7:2]: rdata_ff <= {16'h0000, memcfg_ff, lat_ff};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= GMD_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ****************************************
  // memory configuration register
  // ****************************************
  // no guard against writes mid access; software must keep clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      memory_size_ff <= GMD_RST_SIZE;
      access_latency_select_ff <= GMD_RST_LAT;
    end else if (wr_mem) begin
      memory_size_ff <= mem_nv[GMD_MEM_SIZE_LSB +: 2];
      access_latency_select_ff <= mem_nv[GMD_MEM_LAT_BIT];
    end
  end

  // ****************************************
  // display mode register
  // ****************************************
  // resettable display fields
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      filter_average_enable_ff <= 1'b0;
      background_wrap_enable_ff <= 1'b0;
      background_combine_enable_ff <= 1'b0;
      sync_mode_ff <= GMD_SYNC_TV;
      refresh_count_ff <= GMD_RST_REF;
    end else if (wr_disp) begin
      filter_average_enable_ff <= disp_nv[GMD_DISP_FLT_BIT];
      background_wrap_enable_ff <= disp_nv[GMD_DISP_WRAP_BIT];
      background_combine_enable_ff <= disp_nv[GMD_DISP_COMB_BIT];
      sync_mode_ff <= gmd_sync_e'(disp_nv[GMD_DISP_SYNC_LSB +: 2]);
      refresh_count_ff <= disp_nv[GMD_DISP_REF_LSB +: 4];
    end
  end

  // scan mode has no reset so it survives one; power-up value is unknown
  always_ff @(posedge clock) begin
    if (wr_disp && !reset) begin
      scan_mode_ff <= disp_nv[GMD_DISP_SCAN_LSB +: 2];
    end
  end

  // ****************************************
  // memory decode and latencies
  // ****************************************
  // registered so timing to the memory sequencer stays short
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      memcfg_ff <= '0;
      lat_ff <= '{GMD_LAT_APL, GMD_LAT_SLOW, GMD_LAT_SLOW, GMD_LAT_WPL};
    end else begin
      memcfg_ff.bus32 <= memory_size_ff[0];
      memcfg_ff.two_parts <= (memory_size_ff == 2'h1);
      memcfg_ff.dens64 <= memory_size_ff[1];
      memcfg_ff.part_x32 <= (memory_size_ff == 2'h3);
      lat_ff.active_to_precharge_latency <= GMD_LAT_APL;
      lat_ff.write_to_precharge_latency <= GMD_LAT_WPL;
      lat_ff.pre <= access_latency_select_ff ? GMD_LAT_FAST : GMD_LAT_SLOW;
      lat_ff.rcd <= access_latency_select_ff ? GMD_LAT_FAST : GMD_LAT_SLOW;
    end
  end

  // ****************************************
  // background wrap
  // ****************************************
  // x assumed below twice the width, so one subtraction wraps it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fetch_x_ff <= 12'h000;
      fetch_y_ff <= 14'h0000;
    end else if (background_wrap_enable_ff) begin
      fetch_x_ff <= (bg_x >= rendering_memory_width) ?
                    12'(bg_x - rendering_memory_width) : bg_x;
      fetch_y_ff <= {background_start_coordinate[GMD_BGS_ORG_MSB:GMD_BGS_ORG_LSB],
                     bg_y[GMD_WRAP_Y_BITS-1:0]};
    end else begin
      fetch_x_ff <= bg_x;
      fetch_y_ff <= bg_y;
    end
  end

  // ****************************************
  // sync pin control
  // ****************************************
  // pins become inputs in tv sync and switch modes; csync idles high
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      oe_n_ff <= 1'b1;
      csync_ff <= 1'b1;
      disp_en_ff <= 1'b0;
    end else begin
      oe_n_ff <= (sync_mode_ff != GMD_SYNC_MASTER);
      csync_ff <= 1'b1;
      disp_en_ff <= (sync_mode_ff != GMD_SYNC_SWITCH);
    end
  end

  // ****************************************
  // pixel stage
  // ****************************************
  gmd_filter u_filter (
    .clock(clock),
    .reset(reset),
    .flt_en(filter_average_enable_ff),
    .comb_en(background_combine_enable_ff),
    .pix_valid(pix_valid),
    .pix(pix),
    .colour_key(colour_key),
    .out_valid_ff(out_valid),
    .out_fg_ff(foreground_screen),
    .out_bg_ff(background_screen),
    .out_bg_valid_ff(background_valid),
    .key_hit_ff(colour_key_detect)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign unified_graphics_memory = memcfg_ff;
  assign mem_latency = lat_ff;
  assign bg_fetch_x = fetch_x_ff;
  assign bg_fetch_y = fetch_y_ff;
  assign scan_mode = scan_mode_ff;
  assign refresh_count = refresh_count_ff;
  assign sync_pins_oe_n = oe_n_ff;
  assign csync_out = csync_ff;
  assign display_enable = disp_en_ff;

  // ****************************************
  // checks
  // ****************************************
  sequence s_write_done;
    do_write;
  endsequence

  AST_MEM_RST: assert property (@(posedge clock)
    $fell(reset) |-> memory_size_ff == 2'h0 && !access_latency_select_ff)
    else $error("memory register not cleared by reset");
  AST_DISP_RST: assert property (@(posedge clock)
    $fell(reset) |-> !background_wrap_enable_ff && !background_combine_enable_ff
      && sync_mode_ff == GMD_SYNC_TV && refresh_count_ff == 4'h8)
    else $error("display register reset values wrong");
  AST_SCAN_KEEP: assert property (@(posedge clock)
    reset |=> scan_mode_ff === $past(scan_mode_ff))
    else $error("scan mode changed during reset");
  AST_LAT: assert property (@(posedge clock) disable iff (reset)
    $changed(access_latency_select_ff) |=> lat_ff.pre == ($past(access_latency_select_ff) ?
      3'h2 : 3'h3) && lat_ff.rcd == lat_ff.pre && lat_ff.active_to_precharge_latency == 3'h5)
    else $error("latency set does not follow select bit");
  AST_SIZE: assert property (@(posedge clock) disable iff (reset)
    (memory_size_ff == 2'h1) [*2] |-> memcfg_ff.two_parts && memcfg_ff.bus32 && !memcfg_ff.dens64)
    else $error("two part configuration not decoded");
  AST_RSVD: assert property (@(posedge clock) disable iff (reset)
    s_axi_arvalid && arready_ff && s_axi_araddr[7:2] == GMD_OFS_MEM[7:2]
      |=> rvalid_ff && rdata_ff[31:6] == 26'h0 && rdata_ff[3:1] == 3'h0)
    else $error("reserved memory bits read nonzero");
  AST_WRAP: assert property (@(posedge clock) disable iff (reset)
    background_wrap_enable_ff |=> fetch_y_ff[8:0] == $past(bg_y[8:0])
      && fetch_y_ff[13:9] == $past(background_start_coordinate[13:9]))
    else $error("vertical wrap wrong");
  AST_NOWRAP: assert property (@(posedge clock) disable iff (reset)
    !background_wrap_enable_ff |=> fetch_x_ff == $past(bg_x) && fetch_y_ff == $past(bg_y))
    else $error("background wrapped while wrap off");
  AST_SYNC: assert property (@(posedge clock) disable iff (reset)
    sync_mode_ff == GMD_SYNC_TV |=> oe_n_ff && csync_ff)
    else $error("tv sync mode pins wrong");
  AST_COMB: assert property (@(posedge clock) disable iff (reset)
    pix_valid && !background_combine_enable_ff |=> !background_valid)
    else $error("background merged while combine off");
  AST_BRESP: assert property (@(posedge clock) disable iff (reset)
    s_write_done |=> bvalid_ff ##0 (bvalid_ff throughout !s_axi_bready [*1]) or s_axi_bready)
    else $error("write response missing");
endmodule
`default_nettype wire

// ### verif/gmd_mem_part.sv
/*
  Model of the memory parts attached to the unified graphics memory bus.
  Assumes the decoded configuration comes straight from the register bank.
*/
`timescale 1ns/1ps
`default_nettype none
module gmd_mem_part (
  input wire gmd_pkg::gmd_memcfg_s cfg,
  output var int mbit
);
  import gmd_pkg::*;
  // total capacity seen by the controller, in megabits
  always_comb begin
    mbit = (cfg.dens64 ? 64 : 16) * (cfg.two_parts ? 2 : 1);
  end
endmodule
`default_nettype wire

// ### verif/graphics_memory_display_mode_regs_tb.sv
/*
  Self-checking bench for the register bank, pixel filter and wrap paths.
  Assumes the register bank and the memory part model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module graphics_memory_display_mode_regs_tb;
  import gmd_pkg::*;
  logic clock, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic pix_valid, out_valid, background_valid, colour_key_detect;
  logic sync_pins_oe_n, csync_out, display_enable;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
  logic [3:0] s_axi_wstrb, refresh_count;
  logic [1:0] s_axi_bresp, s_axi_rresp, scan_mode, rsp;
  logic [15:0] colour_key, background_start_coordinate, foreground_screen, background_screen;
  logic [15:0] fg, bg, e;
  logic [11:0] bg_x, rendering_memory_width, bg_fetch_x;
  logic [13:0] bg_y, bg_fetch_y;
  logic [2:0] lt;
  logic [3:0] ue[4] = '{4'h0, 4'hC, 4'h2, 4'hB};
  int mb[4] = '{16, 32, 64, 64};
  gmd_pix_s pix;
  gmd_memcfg_s unified_graphics_memory;
  gmd_lat_s mem_latency;
  int mbit, miscompares, total_checks, cyc;

  gmd_regs gmd_regs_i (.*);
  gmd_mem_part gmd_mem_part_i (.cfg(unified_graphics_memory), .mbit(mbit));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard: well above the couple of hundred cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  endtask

  // each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [15:0] avg(input logic [15:0] a, input logic [15:0] b);
    int r, g, u;
    r = (int'(a[15:11]) + b[15:11]) >> 1;
    g = (int'(a[10:5]) + b[10:5]) >> 1;
    u = (int'(a[4:0]) + b[4:0]) >> 1;
    avg = {r[4:0], g[5:0], u[4:0]};
  endfunction

  initial begin
    {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h21;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pix_valid, pix, colour_key} = '0;
    {bg_x, bg_y, background_start_coordinate} = '0;
    s_axi_wstrb = 4'hF;
    rendering_memory_width = 12'h064;
    void'($urandom(58770));
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rdr(GMD_OFS_MEM);
    chk("mem", 32'h0, rd);
    rdr(GMD_OFS_DISP);
    chk("disp", 32'h88, rd & ~32'h30);
    chk("lat", {3'h5, 3'h3, 3'h3, 3'h2}, mem_latency);
    chk("sync", 2'h3, {sync_pins_oe_n, csync_out});
    for (int s = 0; s < 4; s++) begin
      // no memory traffic runs here, and reserved bits go out as zero
      wr(GMD_OFS_MEM, (s << 4) | (s & 1));
      rdr(GMD_OFS_MEM);
      chk("memcfg", (s << 4) | (s & 1), rd);
      lt = (s & 1) ? 3'h2 : 3'h3;
      rdr(GMD_OFS_STAT);
      chk("stat", {ue[s], 3'h5, lt, lt, 3'h2}, rd);
      chk("mbit", mb[s], mbit);
    end
    // random legal fields only; sync kept to master or switch mode
    d = $urandom & 32'h8C7F;
    wr(GMD_OFS_DISP, d);
    rdr(GMD_OFS_DISP);
    chk("dispres", d & 32'h8CFF, rd);
    chk("dispout", {d[5:4], d[3:0], d[7:6] != 2'h1, d[7:6] != 2'h0},
        {scan_mode, refresh_count, display_enable, sync_pins_oe_n});
    wr(8'h0C, d);
    chk("wresp", GMD_RESP_SLVERR, rsp);
    rdr(8'h0C);
    chk("rresp", GMD_RESP_SLVERR, rsp);
    chk("rdata0", 32'h0, rd);
    // scan mode survives a second reset, the rest returns to defaults
    wr(GMD_OFS_DISP, 32'hB0);
    reset <= 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rdr(GMD_OFS_DISP);
    chk("scan", 32'hB8, rd);
    for (int f = 0; f < 2; f++) begin
      // filter pass sets scan mode 11, plain pass sets wrap and combine, while the pixel stream is idle
      wr(GMD_OFS_DISP, f ? 32'h80B0 : 32'h0C80);
      for (int i = 0; i < 8; i++) begin
        fg = $urandom;
        bg = $urandom;
        e = f ? avg(fg, bg) : fg;
        @(posedge clock);
        pix_valid <= 1'b1;
        pix <= {fg, bg}; // bg stands for the line below fg
        colour_key <= i[0] ? e : ~e;
        bg_x <= 12'($urandom % 200);
        bg_y <= 14'($urandom);
        background_start_coordinate <= 16'($urandom);
        @(posedge clock);
        pix_valid <= 1'b0;
        @(posedge clock);
        chk("fg", {1'b1, e}, {out_valid, foreground_screen});
        chk("bg", f ? 16'h0 : bg, background_screen);
        chk("bgv", f == 0, background_valid);
        chk("key", i[0], colour_key_detect);
        chk("fx", (f == 0 && bg_x >= 100) ? bg_x - 100 : bg_x, bg_fetch_x);
        chk("fy", f ? bg_y : {background_start_coordinate[13:9], bg_y[8:0]}, bg_fetch_y);
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
